//--- pkg/dpc_pkg.sv
package dpc_pkg;
    // register offsets (fieldbus addresses)
    localparam logic [15:0] ADDR_IN1_RISE_POS  = 16'h0a4a;
    localparam logic [15:0] ADDR_IN1_FALL_POS  = 16'h0a4c;
    localparam logic [15:0] ADDR_IN2_RISE_POS  = 16'h0a4e;
    localparam logic [15:0] ADDR_IN2_FALL_POS  = 16'h0a50;
    localparam logic [15:0] ADDR_IN1_RISE_CNT  = 16'h0a56;
    localparam logic [15:0] ADDR_IN1_FALL_CNT  = 16'h0a58;
    localparam logic [15:0] ADDR_IN2_RISE_CNT  = 16'h0a5a;
    localparam logic [15:0] ADDR_IN2_FALL_CNT  = 16'h0a5c;
    localparam logic [15:0] ADDR_PACKED_CNT    = 16'h0a5e;
    localparam logic [15:0] ADDR_CTRL_WORD     = 16'h1b74;
    localparam logic [15:0] ADDR_STATUS_WORD   = 16'h1b76;

    // control word fields, per input stride
    localparam int          CB_STRIDE          = 8;
    localparam int          CB_ACT             = 0;
    localparam int          CB_CONT            = 1;
    localparam int          CB_RISE            = 4;
    localparam int          CB_FALL            = 5;
    localparam logic [15:0] CTRL_MASK          = 16'h3333;
    localparam logic [15:0] CTRL_RESET         = 16'h0000;

    // status word fields, per input stride
    localparam int          ST_ACT             = 0;
    localparam int          ST_RISE            = 1;
    localparam int          ST_FALL            = 2;

    // slot index = input * 2 + edge
    localparam int          NUM_IN             = 2;
    localparam int          NUM_SLOT           = 4;
    localparam int          EDGE_RISE          = 0;
    localparam int          EDGE_FALL          = 1;
    localparam int          CNT_NIB            = 4;

    typedef struct packed {
        logic [1:0]                 sync1;
        logic [1:0]                 sync2;
        logic [1:0]                 prev;
        logic [15:0]                ctrl;
        logic [NUM_SLOT-1:0][31:0]  pos;
        logic [NUM_SLOT-1:0][15:0]  cnt;
        logic [NUM_SLOT-1:0]        done;
        logic [31:0]                rdata;
        logic                       rvalid;
    } dpc_state_t;
endpackage : dpc_pkg

//--- rtl/dpc_capture.sv
`timescale 1ns/10ps
module dpc_capture
(
    input  wire logic        CORE_CLK_I,
    input  wire logic        RESET_N_I,
    input  wire logic [1:0]  CAP_IN_I,
    input  wire logic [31:0] MOTOR_POS_I,
    input  wire logic        POS_REF_SET_I,
    input  wire logic [31:0] POS_REF_DELTA_I,
    input  wire logic [15:0] REG_ADDR_I,
    input  wire logic        REG_RD_I,
    input  wire logic        REG_WR_I,
    input  wire logic [15:0] REG_WDATA_I,
    output logic      [31:0] REG_RDATA_O,
    output logic             REG_RVALID_O
);
    import dpc_pkg::*;

    dpc_state_t q_ff;
    dpc_state_t nxt_q;

    function automatic logic [15:0] status_word(input dpc_state_t s);
        logic [15:0] w;
        w = 16'h0000;
        for (int j = 0; j < NUM_IN; j++) begin
            w[j*CB_STRIDE+ST_ACT]  = s.ctrl[j*CB_STRIDE+CB_ACT];
            w[j*CB_STRIDE+ST_RISE] = s.done[j*2+EDGE_RISE];
            w[j*CB_STRIDE+ST_FALL] = s.done[j*2+EDGE_FALL];
        end
        return w;
    endfunction : status_word

    function automatic logic [15:0] packed_counts(input dpc_state_t s);
        logic [15:0] w;
        w = 16'h0000;
        for (int i = 0; i < NUM_SLOT; i++) begin
            w[i*CNT_NIB +: CNT_NIB] = s.cnt[i][CNT_NIB-1:0];
        end
        return w;
    endfunction : packed_counts

    function automatic logic [31:0] read_mux(input dpc_state_t s,
                                             input logic [15:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            ADDR_IN1_RISE_POS: d = s.pos[0];
            ADDR_IN1_FALL_POS: d = s.pos[1];
            ADDR_IN2_RISE_POS: d = s.pos[2];
            ADDR_IN2_FALL_POS: d = s.pos[3];
            ADDR_IN1_RISE_CNT: d = {16'h0000, s.cnt[0]};
            ADDR_IN1_FALL_CNT: d = {16'h0000, s.cnt[1]};
            ADDR_IN2_RISE_CNT: d = {16'h0000, s.cnt[2]};
            ADDR_IN2_FALL_CNT: d = {16'h0000, s.cnt[3]};
            ADDR_PACKED_CNT:   d = {16'h0000, packed_counts(s)};
            ADDR_CTRL_WORD:    d = {16'h0000, s.ctrl};
            ADDR_STATUS_WORD:  d = {16'h0000, status_word(s)};
            default:           d = 32'h0000_0000;
        endcase
        return d;
    endfunction : read_mux

    logic [NUM_SLOT-1:0] edge_seen;
    logic [NUM_SLOT-1:0] take;
    logic [NUM_IN-1:0]   activating;

    always_comb begin
        nxt_q = q_ff;
        edge_seen = '0;
        take = '0;
        activating = '0;
        // first stage feeds only the second; edges use stages two and three
        nxt_q.sync1 = CAP_IN_I;
        nxt_q.sync2 = q_ff.sync1;
        nxt_q.prev  = q_ff.sync2;
        nxt_q.rvalid = 1'b0;
        if (REG_WR_I && REG_ADDR_I == ADDR_CTRL_WORD) begin
            // reserved control bits are dropped so they cannot enable anything
            nxt_q.ctrl = REG_WDATA_I & CTRL_MASK;
        end
        for (int j = 0; j < NUM_IN; j++) begin
            activating[j] = nxt_q.ctrl[j*CB_STRIDE+CB_ACT]
                          & ~q_ff.ctrl[j*CB_STRIDE+CB_ACT];
            for (int k = 0; k < 2; k++) begin
                edge_seen[j*2+k] = (k == EDGE_RISE) ?
                    (q_ff.sync2[j] & ~q_ff.prev[j]) :
                    (~q_ff.sync2[j] & q_ff.prev[j]);
                take[j*2+k] = edge_seen[j*2+k]
                    & q_ff.ctrl[j*CB_STRIDE+CB_ACT]
                    & q_ff.ctrl[j*CB_STRIDE+CB_RISE+k]
                    & (q_ff.ctrl[j*CB_STRIDE+CB_CONT]
                       | ~q_ff.done[j*2+k]);
                if (POS_REF_SET_I) begin
                    nxt_q.pos[j*2+k] = q_ff.pos[j*2+k]
                                     + POS_REF_DELTA_I;
                end
                // a fresh capture already sees the new reference
                if (take[j*2+k]) begin
                    nxt_q.pos[j*2+k]  = MOTOR_POS_I;
                    nxt_q.cnt[j*2+k]  = q_ff.cnt[j*2+k] + 16'h0001;
                    nxt_q.done[j*2+k] = 1'b1;
                end
                // edges are ignored while inactive, so no capture can collide
                if (activating[j]) begin
                    nxt_q.cnt[j*2+k]  = 16'h0000;
                    nxt_q.done[j*2+k] = 1'b0;
                end
            end
        end
        if (REG_RD_I) begin
            nxt_q.rdata  = read_mux(q_ff, REG_ADDR_I);
            nxt_q.rvalid = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            q_ff <= '0;
            q_ff.ctrl <= CTRL_RESET;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign REG_RDATA_O  = q_ff.rdata;
    assign REG_RVALID_O = q_ff.rvalid;

    logic [15:0] stat;
    assign stat = status_word(q_ff);

    property p_act_shown;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (REG_WR_I && REG_ADDR_I == ADDR_CTRL_WORD)
            |=> (stat[0] == $past(REG_WDATA_I[0]))
             && (stat[8] == $past(REG_WDATA_I[8]));
    endproperty
    a_act_shown: assert property (p_act_shown)
        else $error("activation bits not shown in status");

    property p_rise1_capture;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (q_ff.ctrl[0] && q_ff.ctrl[4] && !POS_REF_SET_I
         && !(REG_WR_I && REG_ADDR_I == ADDR_CTRL_WORD)
         && (q_ff.ctrl[1] || !q_ff.done[0])
         && q_ff.sync2[0] && !q_ff.prev[0])
            |=> q_ff.pos[0] == $past(MOTOR_POS_I) && stat[1]
             && q_ff.cnt[0] == $past(q_ff.cnt[0]) + 16'h0001;
    endproperty
    a_rise1_capture: assert property (p_rise1_capture)
        else $error("rising capture on input one failed");

    property p_fall2_capture;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (q_ff.ctrl[8] && q_ff.ctrl[13] && !POS_REF_SET_I
         && !(REG_WR_I && REG_ADDR_I == ADDR_CTRL_WORD)
         && (q_ff.ctrl[9] || !q_ff.done[3])
         && !q_ff.sync2[1] && q_ff.prev[1])
            |=> q_ff.pos[3] == $past(MOTOR_POS_I) && stat[10];
    endproperty
    a_fall2_capture: assert property (p_fall2_capture)
        else $error("falling capture on input two failed");

    property p_one_time_hold;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (!q_ff.ctrl[1] && q_ff.done[1] && q_ff.ctrl[0] && !POS_REF_SET_I
         && !(REG_WR_I && REG_ADDR_I == ADDR_CTRL_WORD))
            |=> $stable(q_ff.pos[1]) && $stable(q_ff.cnt[1]);
    endproperty
    a_one_time_hold: assert property (p_one_time_hold)
        else $error("one-time capture overwritten");

    property p_disabled_edge;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (!q_ff.ctrl[12] && !(REG_WR_I && REG_ADDR_I == ADDR_CTRL_WORD))
            |=> $stable(q_ff.cnt[2]);
    endproperty
    a_disabled_edge: assert property (p_disabled_edge)
        else $error("disabled edge changed its counter");

    property p_activate_clears;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (REG_WR_I && REG_ADDR_I == ADDR_CTRL_WORD && REG_WDATA_I[8]
         && !q_ff.ctrl[8])
            |=> q_ff.cnt[2] == 16'h0000 && q_ff.cnt[3] == 16'h0000
             && !stat[9] && !stat[10];
    endproperty
    a_activate_clears: assert property (p_activate_clears)
        else $error("activation did not clear counters");

    property p_packed;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        REG_RD_I && REG_ADDR_I == ADDR_PACKED_CNT
            |=> REG_RVALID_O
             && REG_RDATA_O == {16'h0000, $past(q_ff.cnt[3][3:0]),
                   $past(q_ff.cnt[2][3:0]), $past(q_ff.cnt[1][3:0]),
                   $past(q_ff.cnt[0][3:0])};
    endproperty
    a_packed: assert property (p_packed)
        else $error("packed counter word wrong");

    property p_reserved_zero;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        REG_RD_I && REG_ADDR_I == ADDR_STATUS_WORD
            |=> (REG_RDATA_O[31:0] & 32'hffff_f8f8) == 32'h0000_0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved status bits not zero");

    property p_ref_shift;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (POS_REF_SET_I && take == 4'h0)
            |=> q_ff.pos[2] == $past(q_ff.pos[2]) + $past(POS_REF_DELTA_I);
    endproperty
    a_ref_shift: assert property (p_ref_shift)
        else $error("stored position not shifted by reference");

    property p_sync_latency;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        $rose(CAP_IN_I[0]) ##0 (CAP_IN_I[0] [*2])
            |-> q_ff.sync2[0] == 1'b0 ##1 q_ff.sync2[0];
    endproperty
    a_sync_latency: assert property (p_sync_latency)
        else $error("input synchroniser latency wrong");

    property p_fall1_capture;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (q_ff.ctrl[0] && q_ff.ctrl[5] && !POS_REF_SET_I
         && !(REG_WR_I && REG_ADDR_I == ADDR_CTRL_WORD)
         && (q_ff.ctrl[1] || !q_ff.done[1])
         && !q_ff.sync2[0] && q_ff.prev[0])
            |=> q_ff.pos[1] == $past(MOTOR_POS_I) && stat[2]
             && q_ff.cnt[1] == $past(q_ff.cnt[1]) + 16'h0001;
    endproperty
    a_fall1_capture: assert property (p_fall1_capture)
        else $error("falling capture on input one failed");

    property p_rise2_capture;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (q_ff.ctrl[8] && q_ff.ctrl[12] && !POS_REF_SET_I
         && !(REG_WR_I && REG_ADDR_I == ADDR_CTRL_WORD)
         && (q_ff.ctrl[9] || !q_ff.done[2])
         && q_ff.sync2[1] && !q_ff.prev[1])
            |=> q_ff.pos[2] == $past(MOTOR_POS_I) && stat[9]
             && q_ff.cnt[2] == $past(q_ff.cnt[2]) + 16'h0001;
    endproperty
    a_rise2_capture: assert property (p_rise2_capture)
        else $error("rising capture on input two failed");

    property p_once_rise2_hold;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (!q_ff.ctrl[9] && q_ff.done[2] && q_ff.ctrl[8] && !POS_REF_SET_I
         && !(REG_WR_I && REG_ADDR_I == ADDR_CTRL_WORD))
            |=> $stable(q_ff.pos[2]) && $stable(q_ff.cnt[2]);
    endproperty
    a_once_rise2_hold: assert property (p_once_rise2_hold)
        else $error("one-time rising capture overwritten");

    // an input that is not activated must not count or flag anything
    property p_inactive_hold;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (!q_ff.ctrl[0] && !(REG_WR_I && REG_ADDR_I == ADDR_CTRL_WORD))
            |=> $stable(q_ff.cnt[0]) && $stable(q_ff.cnt[1])
             && $stable(q_ff.done[1:0]);
    endproperty
    a_inactive_hold: assert property (p_inactive_hold)
        else $error("inactive input changed its counters");

    property p_activate1_clears;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (REG_WR_I && REG_ADDR_I == ADDR_CTRL_WORD && REG_WDATA_I[0]
         && !q_ff.ctrl[0])
            |=> q_ff.cnt[0] == 16'h0000 && q_ff.cnt[1] == 16'h0000
             && !stat[1] && !stat[2];
    endproperty
    a_activate1_clears: assert property (p_activate1_clears)
        else $error("activation of input one did not clear counters");

    property p_status_read;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        REG_RD_I && REG_ADDR_I == ADDR_STATUS_WORD
            |=> REG_RDATA_O[0] == $past(q_ff.ctrl[0])
             && REG_RDATA_O[8] == $past(q_ff.ctrl[8])
             && REG_RDATA_O[2] == $past(q_ff.done[1])
             && REG_RDATA_O[9] == $past(q_ff.done[2]);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status word read back wrong");
endmodule : dpc_capture

//--- test/dpc_src.sv
`timescale 1ns/10ps
// far side: capture sources and motor encoder, both launched from the edge
// so a level holds steady for whole cycles and the position is stable
module dpc_src (
    input  wire logic        clk_i,
    input  wire logic [1:0]  lvl_i,
    input  wire logic [31:0] pos_i,
    output logic      [1:0]  cap_o,
    output logic      [31:0] pos_o
);
    always_ff @(posedge clk_i) begin
        cap_o <= lvl_i;
        pos_o <= pos_i;
    end
endmodule : dpc_src

//--- test/testbench.sv
`timescale 1ns/10ps
module testbench;
    import dpc_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [1:0]  lvl = 2'h0;
    logic [31:0] mpos = 32'h0;
    logic [1:0]  cap;
    logic [31:0] pos;
    logic        ref_set = 1'b0;
    logic [31:0] ref_delta = 32'h0;
    logic [15:0] addr = 16'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [15:0] wdata = 16'h0;
    logic [31:0] rdata;
    logic        rvalid;
    int          miscompares = 0;
    int          num_checks = 0;
    int          cycles = 0;

    always #20 clk = ~clk;

    dpc_src src (.clk_i(clk), .lvl_i(lvl), .pos_i(mpos), .cap_o(cap),
                 .pos_o(pos));
    dpc_capture dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .CAP_IN_I(cap),
        .MOTOR_POS_I(pos), .POS_REF_SET_I(ref_set),
        .POS_REF_DELTA_I(ref_delta), .REG_ADDR_I(addr), .REG_RD_I(rd),
        .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
        .REG_RVALID_O(rvalid));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    // strobe is taken at the second edge; valid stands one cycle, data holds until the next read
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check({31'h0, rvalid}, 32'h1);
        check(rdata, exp);
    endtask : rd_chk

    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic wr_ctrl(input logic [15:0] d);
        wr_reg(ADDR_CTRL_WORD, d);
    endtask : wr_ctrl

    // level change with a fixed motor position; six edges cover sync + load
    task automatic drive(input int i, input logic v, input logic [31:0] p);
        @(posedge clk);
        mpos <= p;
        lvl[i] <= v;
        repeat (6) @(posedge clk);
    endtask : drive

    task automatic t_reset;
        rd_chk(ADDR_STATUS_WORD, 32'h0);
        rd_chk(ADDR_PACKED_CNT, 32'h0);
        rd_chk(ADDR_IN1_RISE_POS, 32'h0);
        rd_chk(16'h0a52, 32'h0); // unmapped place reads zero
        $display("test reset done");
    endtask : t_reset

    task automatic t_cont;
        wr_ctrl(16'h0033);
        rd_chk(ADDR_STATUS_WORD, 32'h1);
        drive(0, 1'b1, 32'h12345678);
        rd_chk(ADDR_IN1_RISE_POS, 32'h12345678);
        rd_chk(ADDR_STATUS_WORD, 32'h3);
        drive(0, 1'b0, 32'hfedcba98);
        rd_chk(ADDR_IN1_FALL_POS, 32'hfedcba98);
        rd_chk(ADDR_IN1_FALL_CNT, 32'h1);
        rd_chk(ADDR_STATUS_WORD, 32'h7);
        drive(0, 1'b1, 32'h00000100);
        rd_chk(ADDR_IN1_RISE_POS, 32'h00000100);
        rd_chk(ADDR_IN1_RISE_CNT, 32'h2);
        $display("test continuous done");
    endtask : t_cont

    task automatic t_ref;
        @(posedge clk);
        ref_set <= 1'b1;
        ref_delta <= 32'hfffffff0;
        @(posedge clk);
        ref_set <= 1'b0;
        rd_chk(ADDR_IN1_RISE_POS, 32'h000000f0);
        rd_chk(ADDR_IN1_FALL_POS, 32'hfedcba88);
        $display("test reference done");
    endtask : t_ref

    // second input: one-time rise only, fall edges disabled
    task automatic t_once;
        wr_ctrl(16'h1133);
        drive(1, 1'b1, 32'h80000001);
        drive(1, 1'b0, 32'h11111111);
        drive(1, 1'b1, 32'h7fffffff);
        rd_chk(ADDR_IN2_RISE_POS, 32'h80000001);
        rd_chk(ADDR_IN2_RISE_CNT, 32'h1);
        rd_chk(ADDR_IN2_FALL_CNT, 32'h0);
        // the earlier reference shift moved this uncaptured slot as well
        rd_chk(ADDR_IN2_FALL_POS, 32'hfffffff0);
        rd_chk(ADDR_STATUS_WORD, 32'h0307);
        rd_chk(ADDR_PACKED_CNT, 32'h0112);
        $display("test one-time done");
    endtask : t_once

    task automatic t_react;
        wr_ctrl(16'h1132);
        rd_chk(ADDR_STATUS_WORD, 32'h0306);
        // an edge while deactivated leaves position and count alone
        drive(0, 1'b0, 32'h00000055);
        rd_chk(ADDR_IN1_FALL_POS, 32'hfedcba88);
        rd_chk(ADDR_IN1_FALL_CNT, 32'h1);
        wr_ctrl(16'h1133);
        rd_chk(ADDR_IN1_RISE_CNT, 32'h0);
        rd_chk(ADDR_IN1_FALL_CNT, 32'h0);
        rd_chk(ADDR_PACKED_CNT, 32'h0100);
        rd_chk(ADDR_STATUS_WORD, 32'h0301);
        $display("test reactivate done");
    endtask : t_react

    // second input: continuous fall only, rising edges now disabled
    task automatic t_fall2;
        wr_ctrl(16'h2333);
        rd_chk(ADDR_CTRL_WORD, 32'h2333);
        // a write to a read-only place must be dropped
        wr_reg(ADDR_IN2_RISE_CNT, 16'hffff);
        drive(1, 1'b0, 32'h0badf00d);
        rd_chk(ADDR_IN2_FALL_POS, 32'h0badf00d);
        drive(1, 1'b1, 32'h00000001);
        drive(1, 1'b0, 32'h00000002);
        rd_chk(ADDR_IN2_FALL_POS, 32'h00000002);
        rd_chk(ADDR_IN2_FALL_CNT, 32'h2);
        rd_chk(ADDR_IN2_RISE_CNT, 32'h1);
        rd_chk(ADDR_IN2_RISE_POS, 32'h80000001);
        rd_chk(ADDR_STATUS_WORD, 32'h0701);
        rd_chk(ADDR_PACKED_CNT, 32'h2100);
        $display("test falling done");
    endtask : t_fall2

    // reset in mid-run returns every register to its cleared state
    task automatic t_rst2;
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(ADDR_STATUS_WORD, 32'h0);
        rd_chk(ADDR_IN2_FALL_POS, 32'h0);
        rd_chk(ADDR_PACKED_CNT, 32'h0);
        rd_chk(ADDR_CTRL_WORD, 32'h0);
        $display("test second reset done");
    endtask : t_rst2

    always @(posedge clk) begin
        cycles++;
        if (cycles >= 5000) begin
            miscompares++;
            end_of_test();
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_cont();
        t_ref();
        t_once();
        t_react();
        t_fall2();
        t_rst2();
        end_of_test();
    end
endmodule : testbench
